// ### logic/tvn_pkg.sv
/*
 * Package for the trap vector and non-maskable event unit: register map,
 * field positions, reset values and carrier structs.
 * Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
 */
package tvn_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] TVN_ADDR_TRAP_BASE = 8'h00;
	localparam logic [7:0] TVN_ADDR_NM_CAUSE = 8'h04;
	localparam logic [7:0] TVN_ADDR_INIT_LOCK = 8'h08;
	localparam logic [7:0] TVN_ADDR_ISP = 8'h0c;

	// ****************************************************************
	// Reset values and fields
	// ****************************************************************
	localparam logic [31:0] TVN_TRAP_BASE_RST = 32'ha0000100;
	localparam logic [31:0] TVN_NM_CAUSE_RST = 32'h00000000;
	localparam logic [31:0] TVN_ISP_RST = 32'h00000000;
	localparam int TVN_CLASS_SHIFT = 5;
	localparam int TVN_PIN_BIT = 0;
	localparam int TVN_CLK_BIT = 1;
	localparam int TVN_WDG_BIT = 2;
	localparam int TVN_WDG_WAKE_BIT = 15;
	localparam logic [1:0] TVN_IO_PRIV_DFLT = 2'h2;
	localparam logic [1:0] TVN_PRS_DFLT = 2'h0;
	localparam logic [6:0] TVN_CDC_DFLT = 7'h00;
	localparam logic [1:0] TVN_RESP_OKAY = 2'h0;
	localparam logic [1:0] TVN_RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [1:0] io_privilege;
		logic [1:0] protection_set_select;
		logic interrupt_stack_select;
		logic [6:0] call_depth_counter;
	} tvn_status_word_t;

	typedef struct packed {
		logic valid;
		logic [2:0] trap_class_number;
		logic [7:0] trap_id_number;
		logic ctx_switch;
	} tvn_trap_req_t;

	typedef struct packed {
		logic [31:0] handler_addr;
		tvn_status_word_t status_word;
		logic global_irq_enable;
		logic [31:0] stack_pointer_reg;
		logic [31:0] trap_info_data_reg;
	} tvn_entry_t;

	typedef enum logic [1:0] {TVN_IDLE, TVN_SAVE, TVN_LOAD, TVN_FETCH} tvn_state_t;

	typedef struct packed {
		tvn_state_t st;
		tvn_trap_req_t req;
		tvn_entry_t ent;
		logic save_req;
		logic entry_done;
		logic irq_held;
		logic [31:0] trap_base;
		logic [31:0] interrupt_stack_pointer;
		logic init_lock;
		logic [2:0] cause;
		logic nm_req;
		logic pin_s1;
		logic pin_s2;
		logic pin_s3;
		logic wdg_b15;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tvn_state_reg_t;

endpackage

// ### logic/tvn_unit.sv
/*
 * Trap vector and non-maskable event unit: handler address forming,
 * trap-entry sequencing and a clear-on-read non-maskable cause register.
 * Assumes the pipeline performs the context save on save_req and answers
 * with save_done; watchdog and PLL monitor signals are on clk_in.
 */
// Function
// [RULE1] Base resets to fixed default, software changeable
// [RULE2] Base writes only while init lock open
// [RULE3] Base bit zero reads zero, unwritable
// [RULE4] Entry address is base OR class shifted five
// [RULE5] Software keeps base bits seven..five zero
// [RULE6] Class selects entry, id goes to D-reg
// [RULE7] Upper context saved before anything else
// [RULE8] Entry clears irq enable, keeps priority
// [RULE9] Entry loads status word defaults
// [RULE10] Stack pointer from INTERRUPT_STACK_POINTER if IS was zero
// [RULE11] Context-switch trap during save keeps irq pending
// [RULE12] Non-maskable sources each set own flag
// [RULE13] Pin bit0, clock bit1, watchdog bit2
// [RULE14] Software writes never change cause flags
// [RULE15] Request is OR of flags, no re-trigger
// [RULE16] Cause read returns flags then clears
// [RULE17] Pin falling edge sets pin flag
// [RULE18] PLL sync loss sets clock flag
// [RULE19] Watchdog error sets watchdog flag
// [RULE20] Idle watchdog bit15 rise sets watchdog flag
// [RULE21] Software syncs instructions after base change
// [RULE22] Set beats clearing read
`timescale 1ns/1ps
module tvn_unit
	import tvn_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Pipeline side
	input wire tvn_trap_req_t trap_req_in,
	input wire tvn_status_word_t cur_status_word_in,
	input wire logic [31:0] cur_stack_pointer_in,
	input wire logic irq_save_busy_in,
	input wire logic save_done_in,
	input wire logic cpu_idle_in,
	output logic trap_busy_out,
	output logic save_req_out,
	output logic irq_hold_pending_out,
	output logic entry_valid_out,
	output tvn_entry_t entry_out,
	output logic nm_trap_req_out,
	// Far side sources
	input wire logic nm_pin_b_in,
	input wire logic pll_sync_loss_in,
	input wire logic wdg_error_in,
	input wire logic wdg_disabled_in,
	input wire logic [15:0] wdg_count_in
);

	tvn_state_reg_t q;
	tvn_state_reg_t d;

	// ****************************************************************
	// Combinational next state
	// ****************************************************************
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic cause_rd;
	logic [2:0] cause_set;
	logic [31:0] wmask;

	assign s_axi_awready_out = !q.aw_got && !q.bvalid;
	assign s_axi_wready_out = !q.w_got && !q.bvalid;
	assign s_axi_arready_out = !q.rvalid;
	assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_take = s_axi_arvalid_in && s_axi_arready_out;

	always_comb
	begin
		d = q;
		wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
		cause_rd = 1'b0;
		d.entry_done = 1'b0;

		// Pin synchroniser, then edge detect on the synced samples only
		d.pin_s1 = nm_pin_b_in;
		d.pin_s2 = q.pin_s1;
		d.pin_s3 = q.pin_s2;
		d.wdg_b15 = wdg_count_in[TVN_WDG_WAKE_BIT];
		cause_set = 3'h0;
		cause_set[TVN_PIN_BIT] = q.pin_s3 && !q.pin_s2; // RULE17
		cause_set[TVN_CLK_BIT] = pll_sync_loss_in; // RULE18
		cause_set[TVN_WDG_BIT] = wdg_error_in // RULE19
			|| (cpu_idle_in && !wdg_disabled_in && !q.wdg_b15
			&& wdg_count_in[TVN_WDG_WAKE_BIT]); // RULE20

		// Write channel
		if (aw_take)
		begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr_in;
		end
		if (w_take)
		begin
			d.w_got = 1'b1;
			d.w_data = s_axi_wdata_in;
			d.w_strb = s_axi_wstrb_in;
		end
		if (q.aw_got && q.w_got)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = TVN_RESP_OKAY;
			if (q.aw_addr == TVN_ADDR_TRAP_BASE)
			begin
				if (!q.init_lock) // RULE2
				begin
					d.trap_base = ((q.trap_base & ~wmask) | (q.w_data & wmask))
						& 32'hfffffffe; // RULE1 RULE3
				end
			end
			else if (q.aw_addr == TVN_ADDR_NM_CAUSE)
			begin
				// Flags are hardware owned; the write is accepted and dropped
				d.bresp = TVN_RESP_OKAY; // RULE14
			end
			else if (q.aw_addr == TVN_ADDR_INIT_LOCK)
			begin
				if (q.w_strb[0])
				begin
					d.init_lock = q.w_data[0];
				end
			end
			else if (q.aw_addr == TVN_ADDR_ISP)
			begin
				d.interrupt_stack_pointer = (q.interrupt_stack_pointer & ~wmask) | (q.w_data & wmask);
			end
			else
			begin
				d.bresp = TVN_RESP_SLVERR;
			end
		end
		if (q.bvalid && s_axi_bready_in)
		begin
			d.bvalid = 1'b0;
		end

		// Read channel
		if (ar_take)
		begin
			d.rvalid = 1'b1;
			d.rresp = TVN_RESP_OKAY;
			if (s_axi_araddr_in == TVN_ADDR_TRAP_BASE)
			begin
				d.rdata = q.trap_base;
			end
			else if (s_axi_araddr_in == TVN_ADDR_NM_CAUSE)
			begin
				d.rdata = {29'h0, q.cause}; // RULE13
				cause_rd = 1'b1;
			end
			else if (s_axi_araddr_in == TVN_ADDR_INIT_LOCK)
			begin
				d.rdata = {31'h0, q.init_lock};
			end
			else if (s_axi_araddr_in == TVN_ADDR_ISP)
			begin
				d.rdata = q.interrupt_stack_pointer;
			end
			else
			begin
				d.rdata = 32'h0;
				d.rresp = TVN_RESP_SLVERR;
			end
		end
		if (q.rvalid && s_axi_rready_in)
		begin
			d.rvalid = 1'b0;
		end

		// Clear on read, but a set in the same cycle survives
		d.cause = ((cause_rd ? 3'h0 : q.cause) | cause_set); // RULE12 RULE16 RULE22
		// Level OR: a second flag joining an active request adds no new edge
		d.nm_req = |d.cause; // RULE15

		// Trap entry sequence
		case (q.st)
			TVN_IDLE:
			begin
				if (trap_req_in.valid)
				begin
					d.req = trap_req_in;
					d.irq_held = trap_req_in.ctx_switch && irq_save_busy_in; // RULE11
					d.save_req = 1'b1; // RULE7
					d.st = TVN_SAVE;
				end
			end
			TVN_SAVE:
			begin
				// Nothing in the status word moves until the save completes
				if (save_done_in) // RULE7
				begin
					d.save_req = 1'b0;
					d.st = TVN_LOAD;
				end
			end
			TVN_LOAD:
			begin
				d.ent.global_irq_enable = 1'b0; // RULE8
				d.ent.status_word.io_privilege = TVN_IO_PRIV_DFLT; // RULE9
				d.ent.status_word.protection_set_select = TVN_PRS_DFLT;
				d.ent.status_word.interrupt_stack_select = 1'b1;
				d.ent.status_word.call_depth_counter = TVN_CDC_DFLT;
				d.ent.stack_pointer_reg = cur_status_word_in.interrupt_stack_select
					? cur_stack_pointer_in : q.interrupt_stack_pointer; // RULE10
				d.ent.trap_info_data_reg = {24'h0, q.req.trap_id_number}; // RULE6
				d.st = TVN_FETCH;
			end
			TVN_FETCH:
			begin
				// Base bits 7..5 are expected clear so the OR cannot alias
				d.ent.handler_addr = q.trap_base
					| ({29'h0, q.req.trap_class_number} << TVN_CLASS_SHIFT); // RULE4 RULE5 RULE6
				// The held interrupt stays pending past entry; the next accepted trap
				// recomputes it, clearing it unless that trap is again a context switch during a save
				d.entry_done = 1'b1;
				d.st = TVN_IDLE;
			end
			default:
			begin
				d.st = TVN_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			q <= '0;
			q.st <= TVN_IDLE;
			q.trap_base <= TVN_TRAP_BASE_RST; // RULE1
			q.interrupt_stack_pointer <= TVN_ISP_RST;
			q.cause <= TVN_NM_CAUSE_RST[2:0];
			q.pin_s1 <= 1'b1;
			q.pin_s2 <= 1'b1;
			q.pin_s3 <= 1'b1;
			q.wdg_b15 <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_bvalid_out = q.bvalid;
	assign s_axi_bresp_out = q.bresp;
	assign s_axi_rvalid_out = q.rvalid;
	assign s_axi_rdata_out = q.rdata;
	assign s_axi_rresp_out = q.rresp;
	assign trap_busy_out = (q.st != TVN_IDLE);
	assign save_req_out = q.save_req;
	assign irq_hold_pending_out = q.irq_held;
	assign entry_valid_out = q.entry_done;
	assign entry_out = q.ent;
	assign nm_trap_req_out = q.nm_req;

endmodule

// ### bench/tvn_checker.sv
/* Port checker for tvn_unit.
 * Bound to every tvn_unit; one clock domain, synchronous active-low reset. */
`timescale 1ns/1ps
module tvn_checker
	import tvn_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire tvn_trap_req_t trap_req_in,
	input wire tvn_status_word_t cur_status_word_in,
	input wire logic [31:0] cur_stack_pointer_in,
	input wire logic save_done_in,
	input wire logic nm_pin_b_in,
	input wire logic pll_sync_loss_in,
	input wire logic wdg_error_in,
	input wire logic trap_busy_out,
	input wire logic save_req_out,
	input wire logic entry_valid_out,
	input wire tvn_entry_t entry_out,
	input wire logic nm_trap_req_out
);
	tvn_trap_req_t req_q;
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// Accepted request kept for the entry checks
	always_ff @(posedge clk_in)
	begin
		if (trap_req_in.valid && !trap_busy_out)
			req_q <= trap_req_in;
	end
	save_first_a:
		assert property (trap_req_in.valid && !trap_busy_out |=> save_req_out && !entry_valid_out)
		else $error("entry began without a context save");
	entry_time_a:
		assert property (save_req_out && save_done_in |-> ##[1:3] entry_valid_out)
		else $error("entry late after context save");
	status_dflt_a:
		assert property (entry_valid_out |-> !entry_out.global_irq_enable &&
			entry_out.status_word == {TVN_IO_PRIV_DFLT, TVN_PRS_DFLT, 1'h1, TVN_CDC_DFLT})
		else $error("entry status word wrong");
	addr_form_a:
		assert property (entry_valid_out |-> !entry_out.handler_addr[0] &&
			(entry_out.handler_addr[7:5] & req_q.trap_class_number) == req_q.trap_class_number &&
			entry_out.trap_info_data_reg == {24'h0, req_q.trap_id_number})
		else $error("entry address or id wrong");
	stack_keep_a:
		assert property (entry_valid_out && cur_status_word_in.interrupt_stack_select |->
			entry_out.stack_pointer_reg == cur_stack_pointer_in)
		else $error("stack pointer changed");
	pll_flag_a:
		assert property (pll_sync_loss_in |=> nm_trap_req_out)
		else $error("clock loss gave no request");
	wdg_flag_a:
		assert property (wdg_error_in |=> nm_trap_req_out)
		else $error("watchdog error gave no request");
	pin_fall_a:
		assert property ($fell(nm_pin_b_in) |-> ##[2:4] nm_trap_req_out)
		else $error("pin fall gave no request");
endmodule

bind tvn_unit tvn_checker i_tvn_checker (.clk_in, .rst_b_in, .trap_req_in,
	.cur_status_word_in, .cur_stack_pointer_in, .save_done_in, .nm_pin_b_in,
	.pll_sync_loss_in, .wdg_error_in, .trap_busy_out, .save_req_out, .entry_valid_out,
	.entry_out, .nm_trap_req_out);

// ### bench/tvn_pipe_model.sv
/* Pipeline partner: performs the upper context save on request.
 * Assumes save_req holds until the done pulse is taken. */
`timescale 1ns/1ps
module tvn_pipe_model
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic save_req_in,
	input wire logic slow_in,
	output logic save_done_out
);
	logic [3:0] cnt_q;
	// Slow answers stretch the save to expose entry ordering
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || !save_req_in || save_done_out)
		begin
			cnt_q <= 4'h0;
			save_done_out <= 1'h0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			save_done_out <= cnt_q >= (slow_in ? 4'h9 : 4'h0);
		end
	end
endmodule

// ### bench/tb.sv
/* Self-checking bench for tvn_unit with a pipeline partner.
 * Registers over AXI4-Lite; sources driven by the bench. */
`timescale 1ns/1ps
module tb;
	import tvn_pkg::*;
	logic clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
	logic [31:0] s_axi_wdata_in = 32'h0, cur_stack_pointer_in = 32'h5a5a0000;
	logic [31:0] rd_d, base, interrupt_stack_pointer, rnd = 32'h566b;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic [1:0] rd_r, s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, irq_save_busy_in = 1'h0;
	logic cpu_idle_in = 1'h0, nm_pin_b_in = 1'h1, pll_sync_loss_in = 1'h0, slow = 1'h0;
	logic wdg_error_in = 1'h0, wdg_disabled_in = 1'h0, save_done_in, pa, pw;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, trap_busy_out, save_req_out, irq_hold_pending_out;
	logic entry_valid_out, nm_trap_req_out;
	logic [15:0] wdg_count_in = 16'h0;
	logic [31:0] s_axi_rdata_out;
	tvn_trap_req_t trap_req_in = '0;
	tvn_status_word_t cur_status_word_in = '0;
	tvn_entry_t entry_out;
	int bad_count = 0, checked = 0, cyc = 0;
	tvn_unit i_tvn_unit (.*);
	tvn_pipe_model i_tvn_pipe_model (.clk_in, .rst_b_in, .save_req_in(save_req_out),
		.slow_in(slow), .save_done_out(save_done_in));
	always #5 clk_in = !clk_in;
	// ****************
	// Tasks
	// ****************
	function logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [31:0] ent(input logic [31:0] b, input logic [2:0] c);
		return b | {24'h0, c, 5'h0};
	endfunction
	task summarize;
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		{s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
		{pa, pw} = 2'h3;
		// Either channel may be taken first; each drops only after its own take
		while (pa || pw)
		begin
			@(posedge clk_in);
			if (pa && s_axi_awready_out)
			begin
				pa = 1'h0;
				s_axi_awvalid_in <= 1'h0;
			end
			if (pw && s_axi_wready_out)
			begin
				pw = 1'h0;
				s_axi_wvalid_in <= 1'h0;
			end
		end
		do @(posedge clk_in);
		while (!s_axi_bvalid_out);
		rd_r = s_axi_bresp_out;
		s_axi_bready_in <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_in);
		{s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'h3};
		do @(posedge clk_in);
		while (!s_axi_arready_out);
		s_axi_arvalid_in <= 1'h0;
		do @(posedge clk_in);
		while (!s_axi_rvalid_out);
		{rd_d, rd_r} = {s_axi_rdata_out, s_axi_rresp_out};
		s_axi_rready_in <= 1'h0;
	endtask
	task cause(input logic [31:0] e);
		rd(TVN_ADDR_NM_CAUSE);
		chk(rd_d, e);
	endtask
	task src(input logic p, input logic w);
		@(posedge clk_in);
		{pll_sync_loss_in, wdg_error_in} <= {p, w};
		@(posedge clk_in);
		{pll_sync_loss_in, wdg_error_in} <= 2'h0;
	endtask
	task wake(input logic d, input logic [31:0] e);
		{cpu_idle_in, wdg_disabled_in, wdg_count_in} <= {1'h1, d, 16'h7fff};
		tick(2);
		wdg_count_in <= 16'h8000;
		tick(2);
		cause(e);
	endtask
	task trap(input logic [2:0] c, input logic [7:0] id, input logic is, input logic cx);
		@(posedge clk_in);
		trap_req_in <= '{1'h1, c, id, cx};
		{cur_status_word_in.interrupt_stack_select, slow} <= {is, id[0]};
		do @(posedge clk_in);
		while (!trap_busy_out);
		trap_req_in.valid <= 1'h0;
		do @(posedge clk_in);
		while (!entry_valid_out);
		chk(entry_out.handler_addr, ent(base, c));
		chk(entry_out.trap_info_data_reg, {24'h0, id});
		chk(entry_out.stack_pointer_reg, is ? cur_stack_pointer_in : interrupt_stack_pointer);
		chk({20'h0, entry_out.status_word}, {20'h0, 2'h2, 2'h0, 1'h1, 7'h0});
		chk({31'h0, entry_out.global_irq_enable}, 32'h0);
	endtask
	// Hang guard, well above the sequence length
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize;
		end
	end
	initial
	begin
		tick(6);
		rst_b_in <= 1'h1;
		rd(TVN_ADDR_TRAP_BASE);
		chk(rd_d, 32'ha0000100);
		cause(32'h0);
		rd(8'h10);
		chk({30'h0, rd_r}, {30'h0, TVN_RESP_SLVERR});
		rnd = nx(rnd);
		base = rnd & 32'hffffff1e;
		wr(TVN_ADDR_TRAP_BASE, base | 32'h1);
		tick(1);
		rd(TVN_ADDR_TRAP_BASE);
		chk(rd_d, base);
		interrupt_stack_pointer = nx(rnd);
		wr(TVN_ADDR_ISP, interrupt_stack_pointer);
		for (int c = 0; c < 8; c++)
		begin
			rnd = nx(rnd);
			trap(c[2:0], rnd[7:0], rnd[8], 1'h0);
		end
		irq_save_busy_in <= 1'h1;
		trap(3'h5, 8'h33, 1'h0, 1'h1);
		chk({31'h0, irq_hold_pending_out}, 32'h1);
		src(1'h1, 1'h0);
		wr(TVN_ADDR_NM_CAUSE, 32'h0);
		cause(32'h2);
		cause(32'h0);
		src(1'h0, 1'h1);
		cause(32'h4);
		nm_pin_b_in <= 1'h0;
		tick(6);
		cause(32'h1);
		cause(32'h0);
		nm_pin_b_in <= 1'h1;
		tick(6);
		cause(32'h0);
		wake(1'h1, 32'h0);
		wake(1'h0, 32'h4);
		nm_pin_b_in <= 1'h0;
		src(1'h1, 1'h1);
		tick(4);
		chk({31'h0, nm_trap_req_out}, 32'h1);
		cause(32'h7);
		wr(TVN_ADDR_INIT_LOCK, 32'h1);
		wr(TVN_ADDR_TRAP_BASE, 32'h0);
		chk({30'h0, rd_r}, {30'h0, TVN_RESP_OKAY});
		rd(TVN_ADDR_TRAP_BASE);
		chk(rd_d, base);
		summarize;
	end
endmodule
